//--- lfmr_pkg.sv
// package: constants for the firmware memory read link
package lfmr_pkg;
    localparam logic [3:0] START_READ    = 4'hd;
    localparam logic [3:0] SIZE_ONE_BYTE = 4'h0;
    localparam logic [3:0] NIBBLE_ONES   = 4'hf;
    localparam logic [3:0] READY_SYNC    = 4'h0;
    localparam int         ADDR_NIBBLES  = 7;
    localparam int         ADDR_W        = 28;
    localparam int         FLASH_SEL_BIT = 22;
    localparam int         FLASH_ADDR_W  = 19;
    localparam logic [2:0] ADDR_LAST     = 3'h6;
endpackage

//--- lfmr_if.sv
// interface: four-bit multiplexed bus between host and target
`timescale 1ns/10ps
`default_nettype none
interface lfmr_if;
    logic       frame_n;
    logic [3:0] host_dat;
    logic       host_oe;
    logic [3:0] tgt_dat;
    logic       tgt_oe;
    logic [3:0] lad;
    logic       rst_n;

    // wire level: driven value, else pulled high
    assign lad = host_oe ? host_dat : (tgt_oe ? tgt_dat : 4'hf);

    modport host (output frame_n, output host_dat, output host_oe, output rst_n, input lad);
    modport target (input frame_n, input lad, input rst_n, output tgt_dat, output tgt_oe);
endinterface
`default_nettype wire

//--- lfmr_target.sv
// module: target end answering single-byte firmware memory reads
//
// Notes on behaviour
// - respond only to cycles begun with frame low
// - last nibble before frame rises is start
// - start nibble 1101 means read cycle
// - id nibble any value, match straps
// - seven address nibbles, most significant first
// - size nibble zero means one byte
// - host drives ones then floats, turnaround two
// - target takes bus in clock thirteen
// - clock thirteen drives ready sync 0000
// - clock fourteen drives low data nibble
// - clock fifteen drives high data nibble
// - clock sixteen drives ones then releases
// - host takes bus back in clock seventeen
// - fields sampled on rising clock edge
// - id mismatch: ignore cycle, never drive
// - nonzero size: ignore cycle, no response
// - decode bit 22 and bits 18:0
// - frame low mid cycle aborts to idle, or restarts at start if the nibble is 1101
`timescale 1ns/10ps
`default_nettype none
module lfmr_target (
    input  wire logic        CLK_SYS_I,
    input  wire logic        ARST_N_I,
    lfmr_if.target           bus,
    input  wire logic [3:0]  STRAP_SELECT_INPUTS_I,
    input  wire logic [7:0]  RD_DATA_I,
    output logic [18:0]      RD_ADDR_O,
    output logic             RD_FLASH_O,
    output logic             RD_REQ_O
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE,
        S_START,
        S_ID,
        S_ADDR,
        S_SIZE,
        S_TAR0,
        S_TAR1,
        S_SYNC,
        S_DLO,
        S_DHI,
        S_REL,
        S_SKIP
    } lfmr_tst_t;

    typedef struct packed {
        lfmr_tst_t   st;
        logic [2:0]  cnt;
        logic [27:0] addr;
        logic [7:0]  data;
        logic [3:0]  dat;
        logic        oe;
        logic [18:0] rd_addr;
        logic        rd_flash;
        logic        rd_req;
    } lfmr_tgt_t;

    lfmr_tgt_t q, d;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    logic        frame_low;
    logic        bus_reset;
    logic        start_seen;
    logic        id_match;
    logic        size_ok;
    logic        addr_done;
    logic        flash_sel;
    logic [18:0] flash_addr;

    assign frame_low  = ~bus.frame_n;
    assign bus_reset  = ~bus.rst_n;
    assign start_seen = frame_low && (bus.lad == lfmr_pkg::START_READ);
    assign id_match   = (bus.lad == STRAP_SELECT_INPUTS_I);
    assign size_ok    = (bus.lad == lfmr_pkg::SIZE_ONE_BYTE);
    assign addr_done  = (q.cnt == lfmr_pkg::ADDR_LAST);
    assign flash_sel  = q.addr[lfmr_pkg::FLASH_SEL_BIT];
    assign flash_addr = q.addr[lfmr_pkg::FLASH_ADDR_W-1:0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d        = q;
        d.rd_req = 1'b0;
        d.oe     = 1'b0;
        d.dat    = lfmr_pkg::NIBBLE_ONES;
        if (frame_low) begin
            // latest nibble under frame low is the start
            d.cnt = 3'h0;
            if (start_seen) begin
                d.st = S_START;
            end else begin
                d.st = S_IDLE;
            end
        end else begin
            case (q.st)
                S_IDLE: begin
                    d.st = S_IDLE;
                end
                S_START: begin
                    d.cnt = 3'h0;
                    if (id_match) begin
                        d.st = S_ID;
                    end else begin
                        d.st = S_SKIP;
                    end
                end
                S_ID, S_ADDR: begin
                    d.addr = {q.addr[23:0], bus.lad};
                    d.cnt  = q.cnt + 3'h1;
                    if (addr_done) begin
                        d.st = S_SIZE;
                    end else begin
                        d.st = S_ADDR;
                    end
                end
                S_SIZE: begin
                    if (size_ok) begin
                        d.st       = S_TAR0;
                        d.rd_req   = 1'b1;
                        d.rd_flash = flash_sel;
                        d.rd_addr  = flash_addr;
                    end else begin
                        d.st = S_SKIP;
                    end
                end
                S_TAR0: begin
                    d.st = S_TAR1;
                end
                S_TAR1: begin
                    d.st   = S_SYNC;
                    d.data = RD_DATA_I;
                    d.oe   = 1'b1;
                    d.dat  = lfmr_pkg::READY_SYNC;
                end
                S_SYNC: begin
                    d.st  = S_DLO;
                    d.oe  = 1'b1;
                    d.dat = q.data[3:0];
                end
                S_DLO: begin
                    d.st  = S_DHI;
                    d.oe  = 1'b1;
                    d.dat = q.data[7:4];
                end
                S_DHI: begin
                    d.st  = S_REL;
                    d.oe  = 1'b1;
                    d.dat = lfmr_pkg::NIBBLE_ONES;
                end
                S_REL: begin
                    d.st = S_IDLE;
                end
                S_SKIP: begin
                    d.st = S_SKIP;
                end
                default: begin
                    d.st = S_IDLE;
                end
            endcase
        end
        if (bus_reset) begin
            d.st     = S_IDLE;
            d.cnt    = 3'h0;
            d.oe     = 1'b0;
            d.dat    = lfmr_pkg::NIBBLE_ONES;
            d.rd_req = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            q.st       <= S_IDLE;
            q.cnt      <= 3'h0;
            q.addr     <= 28'h0;
            q.data     <= 8'h0;
            q.dat      <= lfmr_pkg::NIBBLE_ONES;
            q.oe       <= 1'b0;
            q.rd_addr  <= 19'h0;
            q.rd_flash <= 1'b0;
            q.rd_req   <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.tgt_dat = q.dat;
    assign bus.tgt_oe  = q.oe;
    assign RD_ADDR_O   = q.rd_addr;
    assign RD_FLASH_O  = q.rd_flash;
    assign RD_REQ_O    = q.rd_req;
endmodule
`default_nettype wire

//--- lfmr_host.sv
// module: host end issuing single-byte firmware memory reads
`timescale 1ns/10ps
`default_nettype none
module lfmr_host (
    input  wire logic        CLK_SYS_I,
    input  wire logic        ARST_N_I,
    lfmr_if.host             bus,
    input  wire logic        REQ_I,
    input  wire logic [3:0]  ID_I,
    input  wire logic [27:0] ADDR_I,
    input  wire logic [3:0]  SIZE_I,
    input  wire logic        BUS_RST_N_I,
    output logic             BUSY_O,
    output logic             DONE_O,
    output logic [7:0]       DATA_O
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        H_IDLE, H_START, H_ID, H_ADDR, H_SIZE, H_TAR0, H_TAR1,
        H_SYNC, H_DLO, H_DHI, H_REL, H_BACK, H_FIN
    } lfmr_hst_t;

    typedef struct packed {
        lfmr_hst_t   st;
        logic [2:0]  cnt;
        logic [27:0] addr;
        logic [3:0]  id;
        logic [3:0]  size;
        logic [7:0]  data;
        logic [3:0]  dat;
        logic        oe;
        logic        frame_n;
        logic        rst_n;
        logic        busy;
        logic        done;
    } lfmr_host_t;

    lfmr_host_t q, d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d         = q;
        d.done    = 1'b0;
        d.frame_n = 1'b1;
        d.oe      = 1'b1;
        d.dat     = lfmr_pkg::NIBBLE_ONES;
        d.rst_n   = BUS_RST_N_I;
        case (q.st)
            H_IDLE: if (REQ_I) begin
                d.st = H_START; d.busy = 1'b1;
                d.addr = ADDR_I; d.id = ID_I; d.size = SIZE_I;
                d.frame_n = 1'b0;
                d.dat = lfmr_pkg::START_READ;
            end
            H_START: begin
                d.st = H_ID; d.dat = q.id; d.cnt = 3'h0;
            end
            H_ID, H_ADDR: begin
                d.st  = (q.cnt == lfmr_pkg::ADDR_LAST) ? H_SIZE : H_ADDR;
                d.dat = q.addr[27:24];
                d.addr = {q.addr[23:0], 4'h0};
                d.cnt = q.cnt + 3'h1;
            end
            H_SIZE: begin
                d.st = H_TAR0; d.dat = q.size;
            end
            H_TAR0: begin
                d.st = H_TAR1; d.dat = lfmr_pkg::NIBBLE_ONES;
            end
            H_TAR1: begin
                d.st = H_SYNC; d.oe = 1'b0;
            end
            H_SYNC: begin
                d.st = H_DLO; d.oe = 1'b0;
            end
            H_DLO: begin
                d.st = H_DHI; d.oe = 1'b0;
            end
            H_DHI: begin
                d.st = H_REL; d.oe = 1'b0; d.data[3:0] = bus.lad;
            end
            H_REL: begin
                d.st = H_BACK;
                d.oe = 1'b0;
                d.data[7:4] = bus.lad;
            end
            H_BACK: begin
                // target still drives ones in clock sixteen, take the bus in seventeen
                d.st = H_FIN;
                d.oe = 1'b1;
            end
            H_FIN: begin
                d.st   = H_IDLE;
                d.busy = 1'b0;
                d.done = 1'b1;
            end
            default: d.st = H_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            q         <= '0;
            q.dat     <= lfmr_pkg::NIBBLE_ONES;
            q.oe      <= 1'b1;
            q.frame_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bus.host_dat = q.dat;
    assign bus.host_oe  = q.oe;
    assign bus.frame_n  = q.frame_n;
    assign bus.rst_n    = q.rst_n;
    assign BUSY_O       = q.busy;
    assign DONE_O       = q.done;
    assign DATA_O       = q.data;
endmodule
`default_nettype wire

//--- lfmr_link_assertions.sv
// checker: timing of the shared nibble bus between host and target
`timescale 1ns/10ps
`default_nettype none
module lfmr_link_assertions (
    input wire logic       CLK_SYS_I,
    input wire logic       ARST_N_I,
    input wire logic       frame_n,
    input wire logic [3:0] host_dat,
    input wire logic       host_oe,
    input wire logic [3:0] tgt_dat,
    input wire logic       tgt_oe,
    input wire logic [3:0] lad,
    input wire logic       rst_n
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);
    AST_READY_SYNC: assert property ($rose(tgt_oe) |-> lad == 4'h0)
        else $error("sync nibble wrong");
    AST_DRIVE_SPAN: assert property ($rose(tgt_oe) |-> tgt_oe[*4] ##1 !tgt_oe)
        else $error("drive span wrong");
    AST_TAR_ONES: assert property ($rose(tgt_oe) |-> ##3 lad == 4'hf && tgt_dat == 4'hf)
        else $error("turnaround not ones");
    AST_SIZE_ZERO: assert property ($rose(tgt_oe) |-> $past(lad, 3) == 4'h0)
        else $error("answer to bad size");
    AST_START_CODE: assert property ($rose(tgt_oe) |-> !$past(frame_n, 12) && $past(lad, 12) == 4'hd)
        else $error("answer without start");
    AST_LAST_START: assert property ($rose(tgt_oe) |-> $past(frame_n, 11))
        else $error("start field misplaced");
    AST_HOST_TAR: assert property ($rose(tgt_oe) |-> $past(host_oe, 2) && !$past(host_oe, 1)
        && $past(host_dat, 2) == 4'hf && $past(lad, 2) == 4'hf)
        else $error("host turnaround wrong");
    AST_ABORT: assert property (!frame_n |=> !tgt_oe)
        else $error("drive during frame");
    AST_BUS_RESET: assert property (!rst_n |=> !tgt_oe)
        else $error("drive during reset");
    AST_ONE_DRIVER: assert property (!(host_oe && tgt_oe))
        else $error("two drivers");
    AST_HOST_BACK: assert property ($fell(tgt_oe) |-> host_oe ##0 (!tgt_oe)[*8])
        else $error("handback wrong");
endmodule
`default_nettype wire

//--- lpc_fw_memory_read_target_tb.sv
// testbench: host and target ends joined, random and corner reads
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("FAIL t=%0t got %h want %h", $time, a, b); end end
module lpc_fw_memory_read_target_tb;
    logic        CLK_SYS_I = 1'b0;
    logic        ARST_N_I  = 1'b0;
    logic        req       = 1'b0;
    logic        bus_rst_n = 1'b1;
    logic [3:0]  id = 4'h0, size = 4'h0, strap = 4'h0;
    logic [27:0] addr      = 28'h0;
    logic [7:0]  rd_data   = 8'h0;
    logic [7:0]  data_o;
    logic [18:0] rd_addr;
    logic        rd_flash, rd_req, busy, done;
    int          n_errors  = 0, n_checks = 0, k;
    lfmr_if link ();
    lfmr_target lfmr_target_i (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .bus(link),
        .STRAP_SELECT_INPUTS_I(strap), .RD_DATA_I(rd_data), .RD_ADDR_O(rd_addr),
        .RD_FLASH_O(rd_flash), .RD_REQ_O(rd_req));
    lfmr_host lfmr_host_i (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .bus(link),
        .REQ_I(req), .ID_I(id), .ADDR_I(addr), .SIZE_I(size), .BUS_RST_N_I(bus_rst_n),
        .BUSY_O(busy), .DONE_O(done), .DATA_O(data_o));
    lfmr_link_assertions lfmr_link_assertions_i (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I),
        .frame_n(link.frame_n), .host_dat(link.host_dat), .host_oe(link.host_oe),
        .tgt_dat(link.tgt_dat), .tgt_oe(link.tgt_oe), .lad(link.lad), .rst_n(link.rst_n));
    // ----
    // helpers
    // ----
    function automatic logic [7:0] byte_of(input logic [27:0] a);
        return a[7:0] ^ {a[22], a[18:12]};
    endfunction
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic xfer(input logic [3:0] i, input logic [27:0] a, input logic [3:0] s,
                        input int rst_at);
        logic [15:0] sh;
        logic [7:0]  b;
        int          nib, reqs, j;
        logic        ok;
        sh = 16'h0;
        nib = 0;
        reqs = 0;
        b = byte_of(a);
        ok = (i == strap) && (s == 4'h0) && (rst_at == 0);
        id = i;
        addr = a;
        size = s;
        rd_data = b;
        req = 1'b1;
        for (j = 0; j < 40 && !(j > 1 && busy === 1'b0); j++) begin
            @(posedge CLK_SYS_I);
            #1;
            req = 1'b0;
            bus_rst_n = !(rst_at != 0 && (j == rst_at || j == rst_at + 1));
            if (link.tgt_oe === 1'b1) begin
                sh = {sh[11:0], link.lad};
                nib++;
                `CHK(link.host_oe, 1'b0)
            end
            if (rd_req === 1'b1) begin
                reqs++;
                `CHK(rd_addr, a[18:0])
                `CHK(rd_flash, a[22])
            end
        end
        `CHK(reqs, ok ? 1 : 0)
        `CHK(nib, ok ? 4 : 0)
        if (ok) begin
            `CHK(sh, {4'h0, b[3:0], b[7:4], 4'hf})
            `CHK(data_o, b)
            `CHK(done, 1'b1)
            `CHK(link.host_oe, 1'b1)
            `CHK(link.tgt_oe, 1'b0)
        end
    endtask
    // ----
    // run
    // ----
    initial forever #50 CLK_SYS_I = ~CLK_SYS_I;
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
    initial begin
        k = $urandom(32'h342e4457);
        repeat (4) @(posedge CLK_SYS_I);
        #1;
        ARST_N_I = 1'b1;
        for (k = 0; k < 12; k++) begin
            strap = 4'($urandom);
            xfer(strap, k == 0 ? 28'h0 : k == 1 ? 28'hfffffff : 28'($urandom), 4'h0, 0);
        end
        $display("test random reads done");
        xfer(strap ^ 4'($urandom_range(1, 15)), 28'($urandom), 4'h0, 0);
        $display("test id mismatch done");
        for (k = 1; k < 16; k += 7) xfer(strap, 28'($urandom), 4'(k), 0);
        $display("test bad size done");
        xfer(strap, 28'($urandom), 4'h0, 6);
        xfer(strap, 28'h0400000, 4'h0, 0);
        $display("test bus reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
